// file: hdl/tfr_pkg.sv
// Constants, command codes and field layouts for the temperature fault response block
//
// Functional notes
// - Internal overtemperature sets none-of-above, MFR word bit, MFR overtemp bit, ALERT.
// - Internal response field bits 7:6; codes 00 and 01 are refused with CML.
// - Internal code 10 disables output at once, then follows retry field.
// - Internal code 11 holds output off while fault lasts, then re-enables.
// - Internal retry 000: no restart, output off until fault cleared.
// - Internal retry codes 001 to 111 are refused with CML.
// - Internal delay bits 2:0 are ignored whatever is written.
// - Latched status clears only by clear-faults, off-then-on cycle, or power-on reset.
// - External overtemperature sets TEMPERATURE bit, temp overtemp bit, ALERT.
// - External undertemperature sets TEMPERATURE bit, temp undertemp bit, ALERT.
// - External faults may take up to 80 ms to be acted on.
// - External overtemp response byte at code 50h, default B8h.
// - External undertemp response byte at code 54h, default B8h.
// - External codes: 00 continue, 10 shut down and retry, 01/11 refused.
// - External retry 111 restarts repeatedly at the programmed interval.
`default_nettype none
package tfr_pkg;

    // ************************************************************
    // Command codes
    // ************************************************************
    localparam logic [7:0] CMD_CLEAR_FAULTS   = 8'h03;
    localparam logic [7:0] CMD_EXT_OT_RESP    = 8'h50;
    localparam logic [7:0] CMD_EXT_UT_RESP    = 8'h54;
    localparam logic [7:0] CMD_STATUS_BYTE    = 8'h78;
    localparam logic [7:0] CMD_STATUS_WORD    = 8'h79;
    localparam logic [7:0] CMD_STATUS_TEMP    = 8'h7D;
    localparam logic [7:0] CMD_STATUS_CML     = 8'h7E;
    localparam logic [7:0] CMD_STATUS_MFR     = 8'h80;
    localparam logic [7:0] CMD_INT_OT_RESP    = 8'hD4;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0] EXT_RESP_RESET     = 8'hB8;
    localparam logic [7:0] INT_RESP_RESET     = 8'hC0;

    // ************************************************************
    // Response byte fields
    // ************************************************************
    localparam int RESP_HI  = 7;
    localparam int RESP_LO  = 6;
    localparam int RETRY_HI = 5;
    localparam int RETRY_LO = 3;
    localparam logic [1:0] RESP_CONTINUE = 2'h0;
    localparam logic [1:0] RESP_SHUTDOWN = 2'h2;
    localparam logic [1:0] RESP_WHILE    = 2'h3;
    localparam logic [2:0] RETRY_NONE    = 3'h0;
    localparam logic [2:0] RETRY_ALWAYS  = 3'h7;

    // ************************************************************
    // Status bit positions
    // ************************************************************
    localparam int SB_NONE_OF_ABOVE = 0;
    localparam int SB_CML           = 1;
    localparam int SB_TEMPERATURE   = 2;
    localparam int SW_MFR           = 12;
    localparam int ST_OT            = 7;
    localparam int ST_UT            = 6;
    localparam int SC_BAD_CMD       = 7;
    localparam int SC_BAD_DATA      = 6;
    localparam int SM_OT            = 6;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_FREQ_HZ         = 20_000_000;
    localparam int RESTART_UNIT_MS     = 1;
    localparam int CYC_PER_RESTART_UNIT = (CLK_FREQ_HZ / 1000) * RESTART_UNIT_MS;
    localparam int EXT_RESPONSE_MAX_MS = 80;

    typedef enum logic [1:0] {
        TFR_EXT_RUN,
        TFR_EXT_LATCHED,
        TFR_EXT_WAIT
    } tfr_ext_state_t;

endpackage : tfr_pkg
`default_nettype wire

// file: hdl/tfr_top.sv
// Temperature fault response: response registers, latched status, output gating
`timescale 1ns/10ps
`default_nettype none
module tfr_top
    import tfr_pkg::*;
#(
    parameter int UNIT_CYCLES = CYC_PER_RESTART_UNIT,
    parameter int INTERVAL_W  = 16
) (
    input  wire logic                  ref_clk_in,
    input  wire logic                  resetn_in,
    input  wire logic                  cmd_wr_in,
    input  wire logic                  cmd_rd_in,
    input  wire logic [7:0]            cmd_code_in,
    input  wire logic [7:0]            cmd_data_in,
    output logic      [15:0]           rd_data_out,
    output logic                       rd_valid_out,
    input  wire logic                  int_ot_fault_in,
    input  wire logic                  ext_ot_fault_in,
    input  wire logic                  ext_ut_fault_in,
    input  wire logic                  run_pin_in,
    input  wire logic                  operation_on_in,
    input  wire logic [INTERVAL_W-1:0] restart_interval_setting_in,
    output logic                       output_enable_out,
    output logic                       alert_o_out,
    output logic                       alert_oe_out
);

    // ************************************************************
    // Reset release and pin synchronisers
    // ************************************************************
    logic       rst_meta_q;
    logic       rst_n_q;
    logic [3:0] pin_meta_q;
    logic [3:0] pin_sync_q;

    // Reset asserts at once, releases after two edges
    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // Sensor comparators and run pin come from outside this domain
    always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pin_meta_q <= 4'h0;
            pin_sync_q <= 4'h0;
        end else begin
            pin_meta_q <= {run_pin_in, ext_ut_fault_in, ext_ot_fault_in, int_ot_fault_in};
            pin_sync_q <= pin_meta_q;
        end
    end

    logic int_ot;
    logic ext_ot;
    logic ext_ut;
    logic run_s;
    assign int_ot = pin_sync_q[0];
    assign ext_ot = pin_sync_q[1];
    assign ext_ut = pin_sync_q[2];
    assign run_s  = pin_sync_q[3];

    // ************************************************************
    // State
    // ************************************************************
    logic [7:0]             ot_resp_q,  ot_resp_d;
    logic [7:0]             ut_resp_q,  ut_resp_d;
    logic [7:0]             int_resp_q, int_resp_d;
    logic [7:0]             st_temp_q,  st_temp_d;
    logic [7:0]             st_cml_q,   st_cml_d;
    logic [7:0]             st_mfr_q,   st_mfr_d;
    logic                   int_off_q,  int_off_d;
    tfr_ext_state_t         ext_q,      ext_d;
    logic [31:0]            unit_q,     unit_d;
    logic [INTERVAL_W-1:0]  ivl_q,      ivl_d;
    logic                   on_q,       on_d;
    logic                   oe_q,       oe_d;
    logic                   alert_q,    alert_d;
    logic [15:0]            rd_q,       rd_d;
    logic                   rv_q,       rv_d;

    logic       cmd_on;
    logic       clr;
    logic       wr_ok;
    logic       ext_trip;
    logic       ext_retry;
    logic [7:0] sbyte;
    logic [15:0] sword;

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb begin
        ot_resp_d  = ot_resp_q;
        ut_resp_d  = ut_resp_q;
        int_resp_d = int_resp_q;
        st_temp_d  = st_temp_q;
        st_cml_d   = st_cml_q;
        st_mfr_d   = st_mfr_q;
        int_off_d  = int_off_q;
        ext_d      = ext_q;
        unit_d     = unit_q;
        ivl_d      = ivl_q;
        rd_d       = rd_q;
        rv_d       = 1'b0;
        wr_ok      = 1'b1;

        cmd_on = run_s & operation_on_in;
        on_d   = cmd_on;
        // Clear by command or by a commanded off edge
        clr = (cmd_wr_in && cmd_code_in == CMD_CLEAR_FAULTS) || (on_q && !cmd_on);

        // Clears first, so that a fault seen in the same cycle wins
        if (clr) begin
            st_temp_d = 8'h00;
            st_cml_d  = 8'h00;
            st_mfr_d  = 8'h00;
            int_off_d = 1'b0;
        end

        // Command writes; refused values leave the register untouched
        if (cmd_wr_in) begin
            case (cmd_code_in)
                CMD_CLEAR_FAULTS: begin
                end
                CMD_EXT_OT_RESP, CMD_EXT_UT_RESP: begin
                    wr_ok = cmd_data_in[RESP_LO] == 1'b0;
                    if (wr_ok && cmd_code_in == CMD_EXT_OT_RESP) begin
                        ot_resp_d = cmd_data_in;
                    end else if (wr_ok) begin
                        ut_resp_d = cmd_data_in;
                    end
                end
                CMD_INT_OT_RESP: begin
                    // Delay bits are stored but never used
                    wr_ok = cmd_data_in[RESP_HI] && cmd_data_in[RETRY_HI:RETRY_LO] == RETRY_NONE;
                    if (wr_ok) begin
                        int_resp_d = cmd_data_in;
                    end
                end
                default: begin
                    st_cml_d[SC_BAD_CMD] = 1'b1;
                end
            endcase
            if (!wr_ok) begin
                st_cml_d[SC_BAD_DATA] = 1'b1;
            end
        end

        // Fault latching is level based: set while present
        if (int_ot) begin
            st_mfr_d[SM_OT] = 1'b1;
        end
        if (ext_ot) begin
            st_temp_d[ST_OT] = 1'b1;
        end
        if (ext_ut) begin
            st_temp_d[ST_UT] = 1'b1;
        end
        if (int_ot && int_resp_q[RESP_HI:RESP_LO] == RESP_SHUTDOWN) begin
            int_off_d = 1'b1;
        end

        // External shutdown with optional endless retry
        ext_trip = (ext_ot && ot_resp_q[RESP_HI:RESP_LO] == RESP_SHUTDOWN) ||
                   (ext_ut && ut_resp_q[RESP_HI:RESP_LO] == RESP_SHUTDOWN);
        ext_retry = (ext_ot && ot_resp_q[RETRY_HI:RETRY_LO] == RETRY_ALWAYS) ||
                    (ext_ut && ut_resp_q[RETRY_HI:RETRY_LO] == RETRY_ALWAYS);
        case (ext_q)
            TFR_EXT_RUN: begin
                // Acted on within a cycle of the synchronised flag, well inside 80 ms
                if (ext_trip) begin
                    unit_d = 32'h0;
                    ivl_d  = '0;
                    ext_d  = ext_retry ? TFR_EXT_WAIT : TFR_EXT_LATCHED;
                end
            end
            TFR_EXT_LATCHED: begin
                if (clr) begin
                    ext_d = TFR_EXT_RUN;
                end
            end
            TFR_EXT_WAIT: begin
                // A commanded off ends retrying
                if (clr) begin
                    ext_d = TFR_EXT_RUN;
                end else if (unit_q == 32'(UNIT_CYCLES - 1)) begin
                    unit_d = 32'h0;
                    if (ivl_q >= restart_interval_setting_in) begin
                        ext_d = TFR_EXT_RUN;
                    end else begin
                        ivl_d = ivl_q + 1'b1;
                    end
                end else begin
                    unit_d = unit_q + 32'h1;
                end
            end
            default: begin
                ext_d = TFR_EXT_RUN;
            end
        endcase

        // Register reads
        if (cmd_rd_in) begin
            rv_d = 1'b1;
            case (cmd_code_in)
                CMD_EXT_OT_RESP: rd_d = {8'h00, ot_resp_q};
                CMD_EXT_UT_RESP: rd_d = {8'h00, ut_resp_q};
                CMD_INT_OT_RESP: rd_d = {8'h00, int_resp_q};
                CMD_STATUS_BYTE: rd_d = {8'h00, sbyte};
                CMD_STATUS_WORD: rd_d = sword;
                CMD_STATUS_TEMP: rd_d = {8'h00, st_temp_q};
                CMD_STATUS_CML:  rd_d = {8'h00, st_cml_q};
                CMD_STATUS_MFR:  rd_d = {8'h00, st_mfr_q};
                default: begin
                    rd_d = 16'h0000;
                    st_cml_d[SC_BAD_CMD] = 1'b1;
                end
            endcase
        end

        // Output gating
        oe_d = cmd_on && !int_off_d && (ext_d == TFR_EXT_RUN) &&
               !(int_ot && int_resp_q[RESP_HI:RESP_LO] == RESP_WHILE);
        alert_d = (st_temp_d != 8'h00) || (st_cml_d != 8'h00) || (st_mfr_d != 8'h00);
    end

    // Summary bits follow the latched detail registers
    assign sbyte = {5'h00, st_temp_q != 8'h00, st_cml_q != 8'h00, st_mfr_q != 8'h00};
    assign sword = {3'h0, st_mfr_q != 8'h00, 4'h0, sbyte};

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ot_resp_q  <= EXT_RESP_RESET;
            ut_resp_q  <= EXT_RESP_RESET;
            int_resp_q <= INT_RESP_RESET;
            st_temp_q  <= 8'h00;
            st_cml_q   <= 8'h00;
            st_mfr_q   <= 8'h00;
            int_off_q  <= 1'b0;
            ext_q      <= TFR_EXT_RUN;
            unit_q     <= 32'h0;
            ivl_q      <= '0;
            on_q       <= 1'b0;
            oe_q       <= 1'b0;
            alert_q    <= 1'b0;
            rd_q       <= 16'h0000;
            rv_q       <= 1'b0;
        end else begin
            ot_resp_q  <= ot_resp_d;
            ut_resp_q  <= ut_resp_d;
            int_resp_q <= int_resp_d;
            st_temp_q  <= st_temp_d;
            st_cml_q   <= st_cml_d;
            st_mfr_q   <= st_mfr_d;
            int_off_q  <= int_off_d;
            ext_q      <= ext_d;
            unit_q     <= unit_d;
            ivl_q      <= ivl_d;
            on_q       <= on_d;
            oe_q       <= oe_d;
            alert_q    <= alert_d;
            rd_q       <= rd_d;
            rv_q       <= rv_d;
        end
    end

    assign output_enable_out = oe_q;
    assign alert_o_out       = 1'b0;      // Open drain: only ever pulls low
    assign alert_oe_out      = alert_q;
    assign rd_data_out       = rd_q;
    assign rd_valid_out      = rv_q;

endmodule : tfr_top
`default_nettype wire

// file: verif/tfr_checker.sv
// Concurrent checks on the ports of the temperature fault response block
`timescale 1ns/10ps
`default_nettype none
module tfr_checker
    import tfr_pkg::*;
(
    input wire logic        ref_clk_in,
    input wire logic        resetn_in,
    input wire logic        cmd_wr_in,
    input wire logic        cmd_rd_in,
    input wire logic [7:0]  cmd_code_in,
    input wire logic [7:0]  cmd_data_in,
    input wire logic [15:0] rd_data_out,
    input wire logic        rd_valid_out,
    input wire logic        int_ot_fault_in,
    input wire logic        ext_ot_fault_in,
    input wire logic        ext_ut_fault_in,
    input wire logic        run_pin_in,
    input wire logic        operation_on_in,
    input wire logic        output_enable_out,
    input wire logic        alert_oe_out
);
    // ************************************************************
    // Helper counters
    // ************************************************************
    logic [3:0] up_q, up_d, clr_q, clr_d;
    logic       up_ok;
    // Settle time after reset, age of the last clearing event
    always_comb begin
        up_d  = (up_q == 4'hF) ? up_q : up_q + 4'h1;
        clr_d = (clr_q == 4'hF) ? clr_q : clr_q + 4'h1;
        if ((cmd_wr_in && cmd_code_in == CMD_CLEAR_FAULTS) || !run_pin_in || !operation_on_in) begin
            clr_d = 4'h0;
        end
    end
    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            up_q  <= 4'h0;
            clr_q <= 4'h0;
        end else begin
            up_q  <= up_d;
            clr_q <= clr_d;
        end
    end
    // Pin syncs must be filled before fault checks mean anything
    assign up_ok = (up_q == 4'hF);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!resetn_in);
    // ************************************************************
    // Properties
    // ************************************************************
    property p_rd_pulse; cmd_rd_in |=> rd_valid_out; endproperty
    property p_rd_only; !cmd_rd_in |=> !rd_valid_out; endproperty
    property p_byte_hi;
        rd_valid_out && $past(cmd_code_in) != CMD_STATUS_WORD |-> rd_data_out[15:8] == 8'h00;
    endproperty
    property p_int_ot; (up_ok && int_ot_fault_in)[*3] |=> alert_oe_out && !output_enable_out; endproperty
    property p_ext_ot; (up_ok && ext_ot_fault_in)[*3] |=> alert_oe_out; endproperty
    property p_ext_ut; (up_ok && ext_ut_fault_in)[*3] |=> alert_oe_out; endproperty
    property p_hold; $fell(alert_oe_out) |-> clr_q < 4'h8; endproperty
    property p_cml_ext;
        cmd_wr_in && (cmd_code_in == CMD_EXT_OT_RESP || cmd_code_in == CMD_EXT_UT_RESP) && cmd_data_in[6]
            |=> alert_oe_out;
    endproperty
    property p_cml_int;
        cmd_wr_in && cmd_code_in == CMD_INT_OT_RESP && (!cmd_data_in[7] || cmd_data_in[5:3] != 3'h0)
            |=> alert_oe_out;
    endproperty
    a_rd_pulse: assert property (p_rd_pulse) else $error("read gave no valid pulse");
    a_rd_only: assert property (p_rd_only) else $error("valid pulse without read");
    a_byte_hi: assert property (p_byte_hi) else $error("byte read upper half not zero");
    a_int_ot: assert property (p_int_ot) else $error("internal fault not acted on");
    a_ext_ot: assert property (p_ext_ot) else $error("external over fault no alert");
    a_ext_ut: assert property (p_ext_ut) else $error("external under fault no alert");
    a_hold: assert property (p_hold) else $error("alert dropped without clear");
    a_cml_ext: assert property (p_cml_ext) else $error("refused external code no alert");
    a_cml_int: assert property (p_cml_int) else $error("refused internal code no alert");
    c_retry: cover property ($rose(output_enable_out) && alert_oe_out);
    c_clear: cover property ($fell(alert_oe_out));
    c_keep_on: cover property (alert_oe_out && output_enable_out);
endmodule : tfr_checker
bind tfr_top tfr_checker i_tfr_checker (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
    .cmd_wr_in(cmd_wr_in), .cmd_rd_in(cmd_rd_in), .cmd_code_in(cmd_code_in), .cmd_data_in(cmd_data_in),
    .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out), .int_ot_fault_in(int_ot_fault_in),
    .ext_ot_fault_in(ext_ot_fault_in), .ext_ut_fault_in(ext_ut_fault_in), .run_pin_in(run_pin_in),
    .operation_on_in(operation_on_in), .output_enable_out(output_enable_out), .alert_oe_out(alert_oe_out));
`default_nettype wire

// file: verif/tfr_host_model.sv
// Host model issuing commands to the fault response block
`timescale 1ns/10ps
`default_nettype none
module tfr_host_model (
    input  wire logic        clk_in,
    input  wire logic [15:0] rd_data_in,
    input  wire logic        rd_valid_in,
    output var  logic        cmd_wr_out,
    output var  logic        cmd_rd_out,
    output var  logic [7:0]  cmd_code_out,
    output var  logic [7:0]  cmd_data_out
);
    // ************************************************************
    // Command cycles
    // ************************************************************
    initial begin
        cmd_wr_out   = 1'b0;
        cmd_rd_out   = 1'b0;
        cmd_code_out = 8'h00;
        cmd_data_out = 8'h00;
    end
    // One-cycle strobe; idle data line flipped so stale values never look valid
    task automatic wr(input logic [7:0] c, input logic [7:0] d);
        @(posedge clk_in);
        cmd_code_out <= c;
        cmd_data_out <= d;
        cmd_wr_out   <= 1'b1;
        @(posedge clk_in);
        cmd_wr_out   <= 1'b0;
        cmd_data_out <= ~d;
    endtask : wr
    // Answer registered on the taking edge itself and sampled 1 ns later, else unknown
    task automatic rd(input logic [7:0] c, output logic [15:0] d);
        @(posedge clk_in);
        cmd_code_out <= c;
        cmd_rd_out   <= 1'b1;
        @(posedge clk_in);
        cmd_rd_out   <= 1'b0;
        #1;
        d = (rd_valid_in === 1'b1) ? rd_data_in : 16'hXXXX;
    endtask : rd
endmodule : tfr_host_model
`default_nettype wire

// file: verif/tb_top.sv
// Self-checking bench for the temperature fault response block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import tfr_pkg::*;
    logic        clk, resetn, wr, rd, rdv, iot, eot, eut, run, op, oen, ao, aoe;
    logic [7:0]  code, data;
    logic [15:0] rdat, ivl;
    int          fails = 0;
    int          checks = 0;
    // ************************************************************
    // Clock, design and host
    // ************************************************************
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    tfr_top #(.UNIT_CYCLES(4), .INTERVAL_W(16)) i_tfr_top (.ref_clk_in(clk), .resetn_in(resetn),
        .cmd_wr_in(wr), .cmd_rd_in(rd), .cmd_code_in(code), .cmd_data_in(data), .rd_data_out(rdat),
        .rd_valid_out(rdv), .int_ot_fault_in(iot), .ext_ot_fault_in(eot), .ext_ut_fault_in(eut),
        .run_pin_in(run), .operation_on_in(op), .restart_interval_setting_in(ivl),
        .output_enable_out(oen), .alert_o_out(ao), .alert_oe_out(aoe));
    tfr_host_model i_tfr_host_model (.clk_in(clk), .rd_data_in(rdat), .rd_valid_in(rdv),
        .cmd_wr_out(wr), .cmd_rd_out(rd), .cmd_code_out(code), .cmd_data_out(data));
    // ************************************************************
    // Helpers
    // ************************************************************
    task automatic end_sim();
        $display("fails=%0d checks=%0d", fails, checks);
        if (fails == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checks++;
        if (g !== e) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task automatic w(input logic [7:0] c, input logic [7:0] d);
        i_tfr_host_model.wr(c, d);
    endtask : w
    task automatic r(input logic [7:0] c, input logic [15:0] e);
        logic [15:0] d;
        i_tfr_host_model.rd(c, d);
        chk(d, e);
    endtask : r
    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_regs();
        r(CMD_EXT_OT_RESP, 16'h00B8);
        r(CMD_EXT_UT_RESP, 16'h00B8);
        w(CMD_EXT_UT_RESP, 8'h07);
        r(CMD_EXT_UT_RESP, 16'h0007);
        r(8'h55, 16'h0000);
        r(CMD_STATUS_CML, 16'h0080);
        w(CMD_CLEAR_FAULTS, 8'h00);
    endtask : t_regs
    // Six refused internal codes and two refused external codes keep the old byte and flag bad data
    task automatic t_cml();
        logic [7:0] bad [8] = '{8'h00, 8'h40, 8'h88, 8'hB8, 8'hF8, 8'hC8, 8'h40, 8'hC0};
        for (int i = 0; i < 8; i++) begin
            w(CMD_CLEAR_FAULTS, 8'h00);
            w(i < 6 ? CMD_INT_OT_RESP : CMD_EXT_OT_RESP, bad[i]);
            r(i < 6 ? CMD_INT_OT_RESP : CMD_EXT_OT_RESP, i < 6 ? 16'h00C0 : 16'h00B8);
            r(CMD_STATUS_CML, 16'h0040);
            r(CMD_STATUS_BYTE, 16'h0002);
        end
        w(CMD_CLEAR_FAULTS, 8'h00);
        cyc(2);
        chk({15'h0, aoe}, 16'h0000);
    endtask : t_cml
    task automatic t_int();
        @(posedge clk) iot <= 1'b1;
        cyc(4);
        chk({15'h0, oen}, 16'h0000);
        chk({14'h0, ao, aoe}, 16'h0001);
        r(CMD_STATUS_BYTE, 16'h0001);
        r(CMD_STATUS_WORD, 16'h1001);
        r(CMD_STATUS_MFR, 16'h0040);
        @(posedge clk) iot <= 1'b0;
        cyc(5);
        chk({14'h0, oen, aoe}, 16'h0003);
        w(CMD_CLEAR_FAULTS, 8'h00);
        w(CMD_INT_OT_RESP, 8'h87);
        r(CMD_STATUS_CML, 16'h0000);
        @(posedge clk) iot <= 1'b1;
        cyc(4);
        @(posedge clk) iot <= 1'b0;
        cyc(30);
        chk({15'h0, oen}, 16'h0000);
        w(CMD_CLEAR_FAULTS, 8'h00);
        cyc(3);
        chk({14'h0, oen, aoe}, 16'h0002);
    endtask : t_int
    // Default byte restarts after (2+1)*4 cycles; status stays latched
    task automatic t_ext();
        int n;
        @(posedge clk) eot <= 1'b1;
        cyc(5);
        chk({15'h0, oen}, 16'h0000);
        @(posedge clk) eot <= 1'b0;
        r(CMD_STATUS_TEMP, 16'h0080);
        r(CMD_STATUS_BYTE, 16'h0004);
        // Trip 3 edges after the pin, restart (2+1)*4 edges later; 10 edges already spent
        for (n = 0; n < 40 && oen !== 1'b1; n++) cyc(1);
        chk({15'h0, oen}, 16'h0001);
        chk(16'(n), 16'h0005);
        if (oen !== 1'b1) return;
        r(CMD_STATUS_TEMP, 16'h0080);
        w(CMD_EXT_UT_RESP, 8'h00);
        @(posedge clk) eut <= 1'b1;
        cyc(5);
        chk({14'h0, oen, aoe}, 16'h0003);
        r(CMD_STATUS_TEMP, 16'h00C0);
        @(posedge clk) eut <= 1'b0;
        w(CMD_EXT_OT_RESP, 8'h80);
        @(posedge clk) eot <= 1'b1;
        cyc(4);
        @(posedge clk) eot <= 1'b0;
        cyc(30);
        chk({15'h0, oen}, 16'h0000);
        @(posedge clk) run <= 1'b0;
        cyc(4);
        @(posedge clk) run <= 1'b1;
        cyc(5);
        r(CMD_STATUS_BYTE, 16'h0000);
        chk({15'h0, oen}, 16'h0001);
        // Shorter interval: trip 3 edges after the pin, restart (1+1)*4 edges later
        w(CMD_EXT_OT_RESP, 8'hB8);
        ivl <= 16'h0001;
        @(posedge clk) eot <= 1'b1;
        cyc(4);
        @(posedge clk) eot <= 1'b0;
        cyc(1);
        for (n = 0; n < 40 && oen !== 1'b1; n++) cyc(1);
        chk(16'(n), 16'h0005);
    endtask : t_ext
    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        resetn = 1'b0;
        {iot, eot, eut} = 3'h0;
        {run, op} = 2'h3;
        ivl = 16'h0002;
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        cyc(6);
        t_regs();
        t_cml();
        t_int();
        t_ext();
        end_sim();
    end
endmodule : tb_top
`default_nettype wire
